// ---- core/cpu_if_active_priority_regs.sv ----
// Aliased group 1 pending register and active priority register sets
// Behaviour
// - Alias returns group 1 pending ID, else 1023
// - Active and pending interrupt never reported
// - Alias accepts Secure accesses only
// - Alias equals Non-secure highest pending read
// - ID in 9:0, source in 12:10
// - Active priority registers always present
// - Secure and Non-secure copies are banked
// - Secure copy holds group 0 priorities
// - Group 1 set holds group 1 priorities
// - Non-secure sees lower priority half, moved down
// - One bit per permitted preemption level
// - Layouts of up to 128 levels, thirty-two by default
// - Group 1 set address reachable by Secure only
// - Group 1 set covers whole priority space
// - Non-secure reaches only Non-secure levels
// - Group 1 set holds distributor view
`default_nettype none
module cpu_if_active_priority_regs #(
    parameter int LEVELS = 32,
    parameter bit SEC_EXT = 1'b1
) (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic WB_NS_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire cpu_apr_pkg::pending_s HP_PEND,
    input wire cpu_apr_pkg::activity_s ACT,
    output logic IRQ
);
    localparam int HALF = LEVELS / 2;
    localparam logic [127:0] IMPL_MASK = (128'h1 << LEVELS) - 128'h1;
    localparam logic [127:0] HALF_MASK = (128'h1 << HALF) - 128'h1;

    logic ack_r;
    logic [31:0] dat_r;
    logic irq_r;
    logic [2:0] status_r;
    logic [2:0] status_nxt;
    logic [2:0] mask_r;
    logic [2:0] mask_nxt;

    logic take;
    logic ns_acc;
    logic hit_alias;
    logic hit_apr;
    logic hit_nsapr;
    logic hit_status;
    logic hit_mask;
    logic any_hit;
    logic [1:0] word_idx;
    logic [6:0] word_lsb;
    logic [31:0] lane32;
    logic [127:0] lane_flat;
    logic [127:0] data_flat;
    logic [31:0] alias_word;
    logic [31:0] rd_data;
    logic [2:0] events;

    logic [127:0] apr_wmask;
    logic [127:0] nsapr_wmask;
    logic [127:0] nsapr_wdata;
    logic [LEVELS-1:0] apr_bits;
    logic [LEVELS-1:0] nsapr_bits;
    logic [127:0] apr_pad;
    logic [127:0] nsapr_pad;
    logic [127:0] ns_view;
    logic level_ok;

    // A new request is taken only while no answer is outstanding
    assign take = WB_CYC_I && WB_STB_I && !ack_r;
    assign ns_acc = SEC_EXT && WB_NS_I;

    assign word_idx = WB_ADR_I[3:2];
    assign word_lsb = {word_idx, 5'h00};
    assign hit_alias = (WB_ADR_I[7:2] == cpu_apr_pkg::OFF_ALIAS_PEND[7:2]);
    assign hit_apr = ((WB_ADR_I & cpu_apr_pkg::BANK_SEL_MASK) == cpu_apr_pkg::OFF_APR_BASE);
    assign hit_nsapr = ((WB_ADR_I & cpu_apr_pkg::BANK_SEL_MASK)
                        == cpu_apr_pkg::OFF_NSAPR_BASE);
    assign hit_status = (WB_ADR_I[7:2] == cpu_apr_pkg::OFF_IRQ_STATUS[7:2]);
    assign hit_mask = (WB_ADR_I[7:2] == cpu_apr_pkg::OFF_IRQ_MASK[7:2]);
    assign any_hit = hit_alias || hit_apr || hit_nsapr || hit_status || hit_mask;

    assign lane32 = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    assign lane_flat = 128'(lane32) << word_lsb;
    assign data_flat = 128'(WB_DAT_I) << word_lsb;

    pend_alias u_pend_alias (
        .pend(HP_PEND),
        .word(alias_word)
    );

    // Secure bank: group 0 priorities, one bit per implemented level
    always_comb begin
        apr_wmask = 128'h0;
        if (take && WB_WE_I && hit_apr && !ns_acc) begin
            apr_wmask = lane_flat & IMPL_MASK;
        end
    end

    // Group 1 set: written by Secure directly, by Non-secure through the remap
    always_comb begin
        nsapr_wmask = 128'h0;
        nsapr_wdata = data_flat;
        if (take && WB_WE_I && hit_nsapr && !ns_acc) begin
            nsapr_wmask = lane_flat & IMPL_MASK;
        end else if (take && WB_WE_I && hit_apr && ns_acc) begin
            nsapr_wmask = (lane_flat & HALF_MASK) << HALF;
            nsapr_wdata = data_flat << HALF;
        end
    end

    // Compared at eight bits so that 128 levels does not wrap to zero
    assign level_ok = ({1'b0, ACT.level} < 8'(LEVELS));

    apr_store #(
        .LEVELS(LEVELS)
    ) u_apr_store (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .wr_mask(apr_wmask[LEVELS-1:0]),
        .wr_data(data_flat[LEVELS-1:0]),
        .set_en(ACT.set && !ACT.group1 && level_ok),
        .clr_en(ACT.clr && !ACT.group1 && level_ok),
        .level(ACT.level),
        .bits(apr_bits)
    );

    apr_store #(
        .LEVELS(LEVELS)
    ) u_nsapr_store (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .wr_mask(nsapr_wmask[LEVELS-1:0]),
        .wr_data(nsapr_wdata[LEVELS-1:0]),
        .set_en(ACT.set && ACT.group1 && level_ok),
        .clr_en(ACT.clr && ACT.group1 && level_ok),
        .level(ACT.level),
        .bits(nsapr_bits)
    );

    assign apr_pad = 128'(apr_bits);
    assign nsapr_pad = 128'(nsapr_bits);
    // Lower priority half of the group 1 set, moved down for Non-secure reads
    assign ns_view = (nsapr_pad >> HALF) & HALF_MASK;

    always_comb begin
        rd_data = 32'h00000000;
        if (hit_alias) begin
            if (!ns_acc) begin
                rd_data = alias_word;
            end
        end else if (hit_apr) begin
            if (ns_acc) begin
                rd_data = ns_view[word_lsb +: 32];
            end else begin
                rd_data = apr_pad[word_lsb +: 32];
            end
        end else if (hit_nsapr) begin
            if (!ns_acc) begin
                rd_data = nsapr_pad[word_lsb +: 32];
            end
        end else if (hit_status) begin
            rd_data = 32'(status_r);
        end else if (hit_mask) begin
            rd_data = 32'(mask_r);
        end
    end

    // Events for the interrupt status register
    always_comb begin
        events = 3'h0;
        events[cpu_apr_pkg::EV_REFUSED] = take && ns_acc && (hit_alias || hit_nsapr);
        events[cpu_apr_pkg::EV_UNMAPPED] = take && !any_hit;
        events[cpu_apr_pkg::EV_LEVEL_RANGE] = (ACT.set || ACT.clr) && !level_ok;
    end

    // Read clears the status; a coincident event still sets its bit
    always_comb begin
        status_nxt = status_r;
        if (take && !WB_WE_I && hit_status) begin
            status_nxt = 3'h0;
        end
        status_nxt = status_nxt | events;
    end

    always_comb begin
        mask_nxt = mask_r;
        if (take && WB_WE_I && hit_mask && WB_SEL_I[0]) begin
            mask_nxt = WB_DAT_I[2:0];
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            status_r <= cpu_apr_pkg::STATUS_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mask_r <= cpu_apr_pkg::MASK_RESET;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_nxt & mask_nxt);
        end
    end

    // One cycle answer; ack drops the cycle after it was given
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= take;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            dat_r <= cpu_apr_pkg::DAT_RESET;
        end else if (take && !WB_WE_I) begin
            dat_r <= rd_data;
        end else begin
            dat_r <= cpu_apr_pkg::DAT_RESET;
        end
    end

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;
    assign IRQ = irq_r;
endmodule
`default_nettype wire

// ---- core/cpu_apr_pkg.sv ----
// Shared constants and carriers for the active priority register block
`default_nettype none
package cpu_apr_pkg;
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int MAX_BITS = 128;

    localparam logic [7:0] OFF_ALIAS_PEND = 8'h00;
    localparam logic [7:0] OFF_APR_BASE = 8'h10;
    localparam logic [7:0] OFF_NSAPR_BASE = 8'h20;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h30;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h34;
    localparam logic [7:0] BANK_SEL_MASK = 8'hF0;

    localparam int ID_LSB = 0;
    localparam int ID_W = 10;
    localparam int SRC_LSB = 10;
    localparam int SRC_W = 3;
    localparam logic [9:0] SPURIOUS_ID = 10'h3FF;
    localparam logic [9:0] SGI_LAST_ID = 10'h00F;

    localparam int EV_W = 3;
    localparam int EV_REFUSED = 0;
    localparam int EV_UNMAPPED = 1;
    localparam int EV_LEVEL_RANGE = 2;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic APR_BIT_RESET = 1'b0;
    localparam logic [31:0] DAT_RESET = 32'h00000000;

    typedef struct packed {
        logic valid;
        logic [9:0] id;
        logic [2:0] src;
        logic group1;
        logic active;
    } pending_s;

    typedef struct packed {
        logic set;
        logic clr;
        logic group1;
        logic [6:0] level;
    } activity_s;
endpackage
`default_nettype wire

// ---- core/pend_alias.sv ----
// Forms the aliased group 1 pending word from the highest pending interrupt
`default_nettype none
module pend_alias (
    input wire cpu_apr_pkg::pending_s pend,
    output logic [31:0] word
);
    always_comb begin
        word = 32'h00000000;
        if (pend.valid && pend.group1 && !pend.active) begin
            word[cpu_apr_pkg::ID_LSB +: cpu_apr_pkg::ID_W] = pend.id;
            if (pend.id <= cpu_apr_pkg::SGI_LAST_ID) begin
                word[cpu_apr_pkg::SRC_LSB +: cpu_apr_pkg::SRC_W] = pend.src;
            end
        end else begin
            word[cpu_apr_pkg::ID_LSB +: cpu_apr_pkg::ID_W] = cpu_apr_pkg::SPURIOUS_ID;
        end
    end
endmodule
`default_nettype wire

// ---- core/apr_store.sv ----
// One bit per preemption level, written by software and by activation hooks
`default_nettype none
module apr_store #(
    parameter int LEVELS = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [LEVELS-1:0] wr_mask,
    input wire logic [LEVELS-1:0] wr_data,
    input wire logic set_en,
    input wire logic clr_en,
    input wire logic [6:0] level,
    output logic [LEVELS-1:0] bits
);
    genvar b;
    generate
        for (b = 0; b < LEVELS; b++) begin : g_bit
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    bits[b] <= cpu_apr_pkg::APR_BIT_RESET;
                end else if (set_en && level == 7'(b)) begin
                    bits[b] <= 1'b1;
                end else if (clr_en && level == 7'(b)) begin
                    bits[b] <= 1'b0;
                end else if (wr_mask[b]) begin
                    bits[b] <= wr_data[b];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- verification/cpu_if_active_priority_regs_chk.sv ----
// Concurrent checks on the register bus and the aliased pending word
`default_nettype none
module cpu_if_active_priority_regs_chk #(
    parameter int LEVELS = 32
) (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic WB_NS_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire cpu_apr_pkg::pending_s HP_PEND
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    wire logic take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire logic rd = take && !WB_WE_I;
    wire logic alias_rd = rd && (WB_ADR_I[7:2] == 6'h00);
    wire logic good = HP_PEND.valid && HP_PEND.group1 && !HP_PEND.active;
    wire logic software_generated_interrupt = HP_PEND.id <= 10'h00F;
    property p_ack; take |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("ack not a single cycle after take");
    property p_idle; !WB_ACK_O |-> WB_DAT_O == 32'h00000000; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero outside ack");
    property p_spur; alias_rd && !WB_NS_I && !good |=> WB_DAT_O == 32'h000003FF; endproperty
    a_spur: assert property (p_spur) else $error("alias not spurious");
    property p_act; alias_rd && !WB_NS_I && HP_PEND.active |=> WB_DAT_O[9:0] == 10'h3FF; endproperty
    a_act: assert property (p_act) else $error("active interrupt reported");
    property p_ns; alias_rd && WB_NS_I |=> WB_DAT_O == 32'h00000000; endproperty
    a_ns: assert property (p_ns) else $error("alias readable non-secure");
    property p_fmt;
        alias_rd && !WB_NS_I && good && software_generated_interrupt |=> WB_DAT_O == {19'h0, $past(HP_PEND.src), $past(HP_PEND.id)};
    endproperty
    a_fmt: assert property (p_fmt) else $error("alias word layout wrong");
    property p_hi;
        rd && !WB_NS_I && WB_ADR_I[7:4] == 4'h1 && WB_ADR_I[3:2] != 2'h0 && LEVELS <= 32
        |=> WB_DAT_O == 32'h00000000;
    endproperty
    a_hi: assert property (p_hi) else $error("unimplemented priority word not zero");
    property p_nsg1; rd && WB_NS_I && WB_ADR_I[7:4] == 4'h2 |=> WB_DAT_O == 32'h00000000; endproperty
    a_nsg1: assert property (p_nsg1) else $error("group 1 set readable non-secure");
endmodule
`default_nettype wire

// ---- verification/cpu_if_active_priority_regs_tb.sv ----
// Self-checking bench for the active priority register block
`default_nettype none
module cpu_if_active_priority_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic ns = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat, r, v, w;
    logic [9:0] id;
    logic [3:0] sel = 4'hF;
    logic ack, irq;
    cpu_apr_pkg::pending_s pend = '0;
    cpu_apr_pkg::activity_s act = '0;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc_cnt = 0;
    logic [32:0] notes[$];
    cpu_if_active_priority_regs #(.LEVELS(32), .SEC_EXT(1'b1)) i_cpu_if_active_priority_regs (
        .REF_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_NS_I(ns), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .HP_PEND(pend), .ACT(act), .IRQ(irq));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Classic cycle: hold the request until ack is sampled, then one idle cycle
    task automatic acc(input logic w_en, input logic [7:0] a, input logic [31:0] d,
        input logic s_ns, input logic [32:0] note);
        notes.push_back(note);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w_en;
        adr <= a;
        wdat <= d;
        ns <= s_ns;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic s_ns, input logic [31:0] exp);
        acc(1'b0, a, 32'h00000000, s_ns, {1'b1, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s_ns);
        acc(1'b1, a, d, s_ns, 33'h000000000);
    endtask
    task automatic pulse(input logic [9:0] a);
        act <= a;
        @(posedge clk);
        act <= '0;
        @(posedge clk);
    endtask
    // Each ack retires the oldest note
    always @(negedge clk) begin
        if (ack === 1'b1) begin
            if (notes[0][32]) check(rdat, notes[0][31:0]);
            void'(notes.pop_front());
        end
    end
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        void'($urandom(65543));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(8'h34, 1'b0, 32'h00000000);
        wr(8'h34, 32'h00000007, 1'b0);
        id = 10'(16 + $urandom % 1000);
        pend <= {1'b1, 10'h007, 3'h5, 1'b1, 1'b0};
        rd(8'h00, 1'b0, 32'h00001407);
        pend <= {1'b1, id, 3'h5, 1'b1, 1'b0};
        rd(8'h00, 1'b0, {22'h0, id});
        rd(8'h00, 1'b1, 32'h00000000);
        pend <= {1'b1, id, 3'h5, 1'b0, 1'b0};
        rd(8'h00, 1'b0, 32'h000003FF);
        pend <= {1'b1, id, 3'h5, 1'b1, 1'b1};
        rd(8'h00, 1'b0, 32'h000003FF);
        pend <= {1'b0, id, 3'h5, 1'b1, 1'b0};
        rd(8'h00, 1'b0, 32'h000003FF);
        r = $urandom;
        v = $urandom;
        w = $urandom;
        wr(8'h10, r, 1'b0);
        wr(8'h20, v, 1'b0);
        wr(8'h10, w, 1'b1);
        rd(8'h10, 1'b0, r);
        rd(8'h10, 1'b1, {16'h0, w[15:0]});
        rd(8'h20, 1'b0, {w[15:0], v[15:0]});
        rd(8'h20, 1'b1, 32'h00000000);
        wr(8'h14, r, 1'b0);
        rd(8'h14, 1'b0, 32'h00000000);
        pulse({1'b1, 1'b0, 1'b0, 7'd5});
        pulse({1'b0, 1'b1, 1'b1, 7'd20});
        pulse({1'b1, 1'b0, 1'b0, 7'd40});
        rd(8'h10, 1'b0, r | 32'h00000020);
        rd(8'h20, 1'b0, {w[15:5], 1'b0, w[3:0], v[15:0]});
        // Only the two low byte lanes of this write may land
        sel <= 4'h3;
        wr(8'h10, ~r, 1'b0);
        sel <= 4'hF;
        rd(8'h10, 1'b0, {r[31:16], ~r[15:0]});
        rd(8'h40, 1'b0, 32'h00000000);
        check({31'h0, irq}, 32'h00000001);
        rd(8'h30, 1'b0, 32'h00000007);
        check({31'h0, irq}, 32'h00000000);
        wr(8'h34, 32'h00000002, 1'b0);
        wr(8'h44, 32'h00000000, 1'b0);
        check({31'h0, irq}, 32'h00000001);
        wr(8'h34, 32'h00000000, 1'b0);
        check({31'h0, irq}, 32'h00000000);
        rd(8'h30, 1'b0, 32'h00000002);
        final_report();
    end
endmodule
bind cpu_if_active_priority_regs cpu_if_active_priority_regs_chk #(
    .LEVELS(LEVELS)
) i_cpu_if_active_priority_regs_chk (
    .REF_CLK(REF_CLK),
    .RST_B(RST_B),
    .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I),
    .WB_NS_I(WB_NS_I),
    .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O),
    .HP_PEND(HP_PEND)
);
`default_nettype wire
